/* rtl/isa_recovery_pkg.sv */
// constants, field layout and types shared by the i/o recovery timer files
package isa_recovery_pkg;

   // register byte addresses on the axi4-lite slave
   localparam logic [7:0] ADDR_RECOV  = 8'h4C;
   localparam logic [7:0] ADDR_DIV    = 8'h50;
   localparam logic [7:0] ADDR_STATUS = 8'h54;

   // reset values
   localparam logic [7:0] RECOV_RESET = 8'h56;
   localparam logic [7:0] DIV_RESET   = 8'h03;

   // field positions of the recovery control register
   localparam int RSVD_BIT  = 7;
   localparam int EN8_BIT   = 6;
   localparam int T8_LSB    = 3;
   localparam int EN16_BIT  = 2;
   localparam int T16_LSB   = 0;

   // field positions of the divisor and status registers
   localparam int DIV_LSB   = 0;
   localparam int DIV_W     = 3;
   localparam int STS_BUSY  = 0;
   localparam int STS_CYC   = 1;
   localparam int STS_WIDE  = 2;
   localparam int STS_CNT   = 4;

   // recovery counts in isa clocks
   localparam logic [3:0] MIN_RECOVERY = 4'h5;
   localparam logic [3:0] T8_ZERO_ADD  = 4'h8;
   localparam logic [3:0] T16_ZERO_ADD = 4'h4;

   // axi4-lite responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // recovery control fields as software programs them
   typedef struct packed {
      logic       en8;
      logic [2:0] time8;
      logic       en16;
      logic [1:0] time16;
   } recov_ctl_s;

   // attributes of the isa cycle now running
   typedef struct packed {
      logic io;
      logic wide;
      logic more;
   } cyc_info_s;

   typedef enum logic [2:0] {
      ST_IDLE    = 3'b001,
      ST_CYCLE   = 3'b010,
      ST_RECOVER = 3'b100
   } recov_state_e;

endpackage

/* rtl/isa_clk_divider.sv */
// isa bus clock generator: divides the system clock by a programmable integer
`timescale 1ns/1ps
module isa_clk_divider
   import isa_recovery_pkg::*;
#(
   parameter int W = DIV_W
) (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic [W-1:0] ratio_i,
   output logic              sysclk_o,
   output logic              tick_o
);

   logic [W-1:0] cnt_ff;
   logic [W-1:0] nxt_cnt;
   logic         sysclk_ff;
   logic         tick_ff;

   // ratio_i + 1 system clocks per isa clock; a new ratio takes effect at once, and a count already at or past it wraps on the next clock
   always_comb begin
      nxt_cnt = (cnt_ff >= ratio_i) ? '0 : W'(cnt_ff + 1'b1);
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_ff <= '0;
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end

   // high half first, so the wrap to zero is the isa rising edge
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sysclk_ff <= 1'b0;
         tick_ff   <= 1'b0;
      end else begin
         sysclk_ff <= (nxt_cnt <= (ratio_i >> 1));
         tick_ff   <= (nxt_cnt == '0);
      end
   end

   assign sysclk_o = sysclk_ff;
   assign tick_o   = tick_ff;

endmodule

/* rtl/isa_io_recovery_timer.sv */
// isa i/o recovery timer with axi4-lite register slave
// Operation
// - at least five isa clocks between i/o cycles
// - gap runs from command rise to next bale
// - no gap between byte assembly sub-cycles
// - bit 6 enables extra 8-bit recovery
// - 8-bit code 001..111 adds 1..7, 000 adds 8
// - bit 2 enables extra 16-bit recovery
// - 16-bit code 01..11 adds 1..3, 00 adds 4
// - bit 7 reserved, reads zero
// - register resets to 56h
// - isa clock is divided system clock
`timescale 1ns/1ps
module isa_io_recovery_timer
   import isa_recovery_pkg::*;
#(
   parameter int AW = 8
) (
   input  wire logic          CLOCK_I,
   input  wire logic          RST_I,
   // axi4-lite slave
   input  wire logic [AW-1:0] S_AXI_AWADDR_I,
   input  wire logic          S_AXI_AWVALID_I,
   output logic               S_AXI_AWREADY_O,
   input  wire logic [31:0]   S_AXI_WDATA_I,
   input  wire logic [3:0]    S_AXI_WSTRB_I,
   input  wire logic          S_AXI_WVALID_I,
   output logic               S_AXI_WREADY_O,
   output logic [1:0]         S_AXI_BRESP_O,
   output logic               S_AXI_BVALID_O,
   input  wire logic          S_AXI_BREADY_I,
   input  wire logic [AW-1:0] S_AXI_ARADDR_I,
   input  wire logic          S_AXI_ARVALID_I,
   output logic               S_AXI_ARREADY_O,
   output logic [31:0]        S_AXI_RDATA_O,
   output logic [1:0]         S_AXI_RRESP_O,
   output logic               S_AXI_RVALID_O,
   input  wire logic          S_AXI_RREADY_I,
   // isa cycle generator side
   input  wire logic          CYC_REQ_I,
   output logic               CYC_GNT_O,
   input  wire logic          IO_CYCLE_I,
   input  wire logic          WIDE_CYCLE_I,
   input  wire logic          MORE_SUBCYCLES_I,
   input  wire logic          IO_CMD_N_I,
   output logic               SYSCLK_O
);

   // ------------------------------------------------------------------
   // how the gap is made
   //   the cycle generator asks for a new address-latch strobe on
   //   CYC_REQ_I and may only raise it while CYC_GNT_O is high.
   //   a falling command strobe marks the start of a cycle, and the
   //   cycle's attributes are latched at that moment.
   //   a rising command strobe ends the cycle. if it was the last
   //   i/o sub-cycle of an access, the counter loads the total for
   //   its width and the grant stays low until the count runs out.
   //   the count moves only on isa clock ticks, so a divisor written
   //   in mid-gap stretches or shrinks the rest of that gap.
   //   the first tick after the command rise may be a partial isa
   //   clock when the command does not rise on an isa clock edge.
   //   memory cycles and sub-cycles that are not the last one go
   //   straight back to idle, so byte assembly is never slowed.
   // ------------------------------------------------------------------

   recov_ctl_s        ctl_ff;
   logic [DIV_W-1:0]  div_ff;
   recov_state_e      state_ff;
   recov_state_e      nxt_state;
   cyc_info_s         cyc_ff;
   logic [3:0]        cnt_ff;
   logic [3:0]        nxt_cnt;
   logic              cmd_n_q_ff;
   logic              cmd_fall;
   logic              cmd_rise;
   logic              isa_tick;
   logic [3:0]        extra8;
   logic [3:0]        extra16;
   logic [3:0]        total;

   // axi state
   logic [AW-1:0]     awaddr_ff;
   logic              aw_full_ff;
   logic [31:0]       wdata_ff;
   logic [3:0]        wstrb_ff;
   logic              w_full_ff;
   logic              bvalid_ff;
   logic [1:0]        bresp_ff;
   logic              rvalid_ff;
   logic [1:0]        rresp_ff;
   logic [31:0]       rdata_ff;
   logic              do_write;
   logic              do_read;
   logic [31:0]       rd_mux;
   logic              rd_hit;

   // isa clock source; the count below only moves on its rising edges
   isa_clk_divider #(
      .W (DIV_W)
   ) u_div (
      .clk_i    (CLOCK_I),
      .rst_i    (RST_I),
      .ratio_i  (div_ff),
      .sysclk_o (SYSCLK_O),
      .tick_o   (isa_tick)
   );

   // ------------------------------------------------------------------
   // command strobe edges; inputs are synchronous to CLOCK_I
   always_ff @(posedge CLOCK_I or posedge RST_I) begin
      if (RST_I) begin
         cmd_n_q_ff <= 1'b1;
      end else begin
         cmd_n_q_ff <= IO_CMD_N_I;
      end
   end

   assign cmd_fall = cmd_n_q_ff & ~IO_CMD_N_I;
   assign cmd_rise = ~cmd_n_q_ff & IO_CMD_N_I;

   // cycle attributes latched while the command starts
   always_ff @(posedge CLOCK_I or posedge RST_I) begin
      if (RST_I) begin
         cyc_ff <= '0;
      end else if (cmd_fall) begin
         cyc_ff <= '{io: IO_CYCLE_I, wide: WIDE_CYCLE_I, more: MORE_SUBCYCLES_I};
      end
   end

   // ------------------------------------------------------------------
   // recovery total for the cycle that just ended
   always_comb begin
      extra8  = (ctl_ff.time8 == 3'h0) ? T8_ZERO_ADD : {1'b0, ctl_ff.time8};
      extra16 = (ctl_ff.time16 == 2'h0) ? T16_ZERO_ADD : {2'b00, ctl_ff.time16};
      if (cyc_ff.wide) begin
         total = MIN_RECOVERY + (ctl_ff.en16 ? extra16 : 4'h0);
      end else begin
         total = MIN_RECOVERY + (ctl_ff.en8 ? extra8 : 4'h0);
      end
   end

   // sequencer: idle -> cycle on command fall -> recover on command rise
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt   = cnt_ff;
      unique case (state_ff)
         ST_IDLE: begin
            if (cmd_fall) begin
               nxt_state = ST_CYCLE;
            end
         end
         ST_CYCLE: begin
            if (cmd_rise) begin
               // sub-cycles of one access run back to back
               if (cyc_ff.io && !cyc_ff.more) begin
                  nxt_state = ST_RECOVER;
                  nxt_cnt   = total;
               end else begin
                  nxt_state = ST_IDLE;
               end
            end
         end
         ST_RECOVER: begin
            // count isa clock ticks, the first possibly partial; exit once the last one has passed
            if (isa_tick) begin
               nxt_cnt = cnt_ff - 4'h1;
               if (cnt_ff == 4'h1) begin
                  nxt_state = ST_IDLE;
               end
            end
         end
         default: begin
            nxt_state = ST_IDLE;
            nxt_cnt   = 4'h0;
         end
      endcase
   end


   // sequencer state and recovery count; both clear so the first
   // cycle after reset is granted without any gap
   always_ff @(posedge CLOCK_I or posedge RST_I) begin
      if (RST_I) begin
         state_ff <= ST_IDLE;
         cnt_ff   <= 4'h0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff   <= nxt_cnt;
      end
   end

   // the next bale may only start while idle; this is what stretches the gap
   assign CYC_GNT_O = CYC_REQ_I && (state_ff == ST_IDLE) && IO_CMD_N_I;

   // ------------------------------------------------------------------
   // axi write: address and data are taken independently, response after both
   assign S_AXI_AWREADY_O = ~aw_full_ff & ~bvalid_ff;
   assign S_AXI_WREADY_O  = ~w_full_ff & ~bvalid_ff;
   assign do_write        = aw_full_ff & w_full_ff & ~bvalid_ff;

   always_ff @(posedge CLOCK_I or posedge RST_I) begin
      if (RST_I) begin
         aw_full_ff <= 1'b0;
         awaddr_ff  <= '0;
      end else if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
         aw_full_ff <= 1'b1;
         awaddr_ff  <= S_AXI_AWADDR_I;
      end else if (do_write) begin
         aw_full_ff <= 1'b0;
      end
   end

   always_ff @(posedge CLOCK_I or posedge RST_I) begin
      if (RST_I) begin
         w_full_ff <= 1'b0;
         wdata_ff  <= 32'h0;
         wstrb_ff  <= 4'h0;
      end else if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
         w_full_ff <= 1'b1;
         wdata_ff  <= S_AXI_WDATA_I;
         wstrb_ff  <= S_AXI_WSTRB_I;
      end else if (do_write) begin
         w_full_ff <= 1'b0;
      end
   end

   // registers live in byte lane 0; other lanes are ignored
   always_ff @(posedge CLOCK_I or posedge RST_I) begin
      if (RST_I) begin
         ctl_ff <= recov_ctl_s'(RECOV_RESET[RSVD_BIT-1:0]);
         div_ff <= DIV_RESET[DIV_LSB +: DIV_W];
      end else if (do_write && wstrb_ff[0]) begin
         if (awaddr_ff == AW'(ADDR_RECOV)) begin
            ctl_ff <= recov_ctl_s'(wdata_ff[RSVD_BIT-1:0]);
         end
         if (awaddr_ff == AW'(ADDR_DIV)) begin
            div_ff <= wdata_ff[DIV_LSB +: DIV_W];
         end
      end
   end

   // status is read-only: a write to it is accepted and dropped
   always_ff @(posedge CLOCK_I or posedge RST_I) begin
      if (RST_I) begin
         bvalid_ff <= 1'b0;
         bresp_ff  <= RESP_OKAY;
      end else if (do_write) begin
         bvalid_ff <= 1'b1;
         bresp_ff  <= (awaddr_ff == AW'(ADDR_RECOV) || awaddr_ff == AW'(ADDR_DIV) ||
                       awaddr_ff == AW'(ADDR_STATUS)) ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_BREADY_I) begin
         bvalid_ff <= 1'b0;
      end
   end

   assign S_AXI_BVALID_O = bvalid_ff;
   assign S_AXI_BRESP_O  = bresp_ff;

   // ------------------------------------------------------------------
   // axi read: one outstanding read, data registered at the take and valid in the cycle after
   assign S_AXI_ARREADY_O = ~rvalid_ff;
   assign do_read         = S_AXI_ARVALID_I & ~rvalid_ff;

   always_comb begin
      rd_mux = 32'h0;
      rd_hit = 1'b1;
      if (S_AXI_ARADDR_I == AW'(ADDR_RECOV)) begin
         rd_mux[RSVD_BIT-1:0] = ctl_ff;
      end else if (S_AXI_ARADDR_I == AW'(ADDR_DIV)) begin
         rd_mux[DIV_LSB +: DIV_W] = div_ff;
      end else if (S_AXI_ARADDR_I == AW'(ADDR_STATUS)) begin
         rd_mux[STS_BUSY]     = (state_ff == ST_RECOVER);
         rd_mux[STS_CYC]      = (state_ff == ST_CYCLE);
         rd_mux[STS_WIDE]     = cyc_ff.wide;
         rd_mux[STS_CNT +: 4] = cnt_ff;
      end else begin
         rd_hit = 1'b0;
      end
   end


   // read response; the data is frozen at the take, so a status word
   // shows the state of the cycle in which the address was accepted
   always_ff @(posedge CLOCK_I or posedge RST_I) begin
      if (RST_I) begin
         rvalid_ff <= 1'b0;
         rdata_ff  <= 32'h0;
         rresp_ff  <= RESP_OKAY;
      end else if (do_read) begin
         rvalid_ff <= 1'b1;
         rdata_ff  <= rd_mux;
         rresp_ff  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_RREADY_I) begin
         rvalid_ff <= 1'b0;
      end
   end


   // read channel outputs straight from their flip-flops
   assign S_AXI_RVALID_O = rvalid_ff;
   assign S_AXI_RDATA_O  = rdata_ff;
   assign S_AXI_RRESP_O  = rresp_ff;

endmodule

/* tb/isa_recovery_checker_assertions.sv */
// port-level assertions for the isa i/o recovery timer
`timescale 1ns/1ps
module isa_recovery_checker
   import isa_recovery_pkg::*;
#(
   parameter int AW = 8
) (
   input wire logic          CLOCK_I,
   input wire logic          RST_I,
   input wire logic [AW-1:0] S_AXI_ARADDR_I,
   input wire logic          S_AXI_ARVALID_I,
   input wire logic          S_AXI_ARREADY_O,
   input wire logic [31:0]   S_AXI_RDATA_O,
   input wire logic          S_AXI_RVALID_O,
   input wire logic          S_AXI_RREADY_I,
   input wire logic          S_AXI_BVALID_O,
   input wire logic          S_AXI_AWREADY_O,
   input wire logic          S_AXI_WREADY_O,
   input wire logic          CYC_REQ_I,
   input wire logic          CYC_GNT_O,
   input wire logic          IO_CYCLE_I,
   input wire logic          MORE_SUBCYCLES_I,
   input wire logic          IO_CMD_N_I
);
   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (RST_I);
   logic          rec_ff;
   logic [AW-1:0] ra_ff;
   // only a last i/o sub-cycle owes a gap; attributes count where the command falls
   always_ff @(posedge CLOCK_I or posedge RST_I) begin
      if (RST_I) rec_ff <= 1'b0;
      else if ($fell(IO_CMD_N_I)) rec_ff <= IO_CYCLE_I & ~MORE_SUBCYCLES_I;
   end
   // read address kept so the answer can be judged per register
   always_ff @(posedge CLOCK_I) begin
      if (S_AXI_ARVALID_I & S_AXI_ARREADY_O) ra_ff <= S_AXI_ARADDR_I;
   end
   sequence s_io_end; $rose(IO_CMD_N_I) && rec_ff; endsequence
   sequence s_sub_end; $rose(IO_CMD_N_I) && !rec_ff; endsequence
   property p_min_gap; s_io_end |-> !CYC_GNT_O [*5]; endproperty
   a_min_gap: assert property (p_min_gap) else $error("grant inside gap");
   property p_gnt; CYC_GNT_O |-> CYC_REQ_I && IO_CMD_N_I; endproperty
   a_gnt: assert property (p_gnt) else $error("grant without cause");
   property p_sub; s_sub_end |=> CYC_GNT_O == CYC_REQ_I; endproperty
   a_sub: assert property (p_sub) else $error("gap after sub-cycle");
   property p_busy; S_AXI_BVALID_O |-> !S_AXI_AWREADY_O && !S_AXI_WREADY_O; endproperty
   a_busy: assert property (p_busy) else $error("write taken while busy");
   property p_ar; S_AXI_ARREADY_O == !S_AXI_RVALID_O; endproperty
   a_ar: assert property (p_ar) else $error("arready wrong");
   property p_rtake; S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O; endproperty
   a_rtake: assert property (p_rtake) else $error("read not answered");
   property p_rdrop; S_AXI_RVALID_O && S_AXI_RREADY_I |=> !S_AXI_RVALID_O; endproperty
   a_rdrop: assert property (p_rdrop) else $error("rvalid kept");
   property p_rsvd; S_AXI_RVALID_O && ra_ff == ADDR_RECOV |-> !S_AXI_RDATA_O[RSVD_BIT]; endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
endmodule

bind isa_io_recovery_timer isa_recovery_checker #(.AW(AW)) u_chk (
   .CLOCK_I, .RST_I, .S_AXI_ARADDR_I, .S_AXI_ARVALID_I, .S_AXI_ARREADY_O,
   .S_AXI_RDATA_O, .S_AXI_RVALID_O, .S_AXI_RREADY_I, .S_AXI_BVALID_O,
   .S_AXI_AWREADY_O, .S_AXI_WREADY_O, .CYC_REQ_I, .CYC_GNT_O, .IO_CYCLE_I,
   .MORE_SUBCYCLES_I, .IO_CMD_N_I
);

/* tb/isa_cycle_model.sv */
// isa cycle generator model: asks for a cycle, runs the command, measures the gap
`timescale 1ns/1ps
module isa_cycle_model
   import isa_recovery_pkg::*;
(
   input  wire logic  clk_i,
   input  wire logic  sysclk_i,
   input  wire logic  gnt_i,
   output logic       req_o = 1'b0,
   output logic       cmd_n_o = 1'b1,
   output cyc_info_s  info_o = 3'h0,
   output logic [7:0] gap_o = 8'h0
);
   int ticks = 0;
   int t0 = 0;
   // isa clocks seen, so the gap is counted in the clock the rule speaks of
   always @(posedge sysclk_i) ticks <= ticks + 1;
   // grant is looked at on the falling edge, where it has settled
   task automatic run(input cyc_info_s c);
      int n;
      n = 0;
      @(posedge clk_i);
      req_o <= 1'b1;
      info_o <= c;
      do @(negedge clk_i); while (gnt_i !== 1'b1 && ++n < 500);
      gap_o <= 8'(ticks - t0);
      @(posedge clk_i);
      req_o <= 1'b0;
      cmd_n_o <= 1'b0;
      repeat (3) @(posedge clk_i);
      cmd_n_o <= 1'b1;
      // attributes mean nothing once the command ends, so show garbage
      info_o <= ~c;
      t0 = ticks;
   endtask
endmodule

/* tb/tb_isa_io_recovery_timer.sv */
// self-checking bench for the isa i/o recovery timer
`timescale 1ns/1ps
module tb_isa_io_recovery_timer
   import isa_recovery_pkg::*;
;
   localparam cyc_info_s IO8 = 3'h4;
   localparam cyc_info_s IO16 = 3'h6;
   localparam cyc_info_s SUB = 3'h5;
   localparam cyc_info_s MEM = 3'h0;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  awaddr = 8'h0;
   logic [7:0]  araddr = 8'h0;
   logic [31:0] wdata = 32'h0;
   logic [3:0]  wstrb = 4'hF;
   logic        awvalid = 1'b0;
   logic        wvalid = 1'b0;
   logic        bready = 1'b0;
   logic        arvalid = 1'b0;
   logic        rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, req, cmd_n, gnt, sysclk;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   logic [7:0]  gapv;
   cyc_info_s   info;
   int          err_count = 0;
   int          total_checks = 0;
   initial forever #25 clk = ~clk;
   isa_io_recovery_timer dut (
      .CLOCK_I(clk), .RST_I(rst), .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid),
      .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb),
      .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp),
      .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr),
      .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata),
      .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready),
      .CYC_REQ_I(req), .CYC_GNT_O(gnt), .IO_CYCLE_I(info.io), .WIDE_CYCLE_I(info.wide),
      .MORE_SUBCYCLES_I(info.more), .IO_CMD_N_I(cmd_n), .SYSCLK_O(sysclk));
   isa_cycle_model m (.clk_i(clk), .sysclk_i(sysclk), .gnt_i(gnt), .req_o(req),
      .cmd_n_o(cmd_n), .info_o(info), .gap_o(gapv));
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %0t value %0h expected %0h", $time, got, exp);
      end
   endtask
   // the first isa clock after the command may be partial, so allow one extra
   task automatic cmp_gap(input logic [7:0] exp);
      total_checks++;
      if (gapv !== exp && gapv !== exp + 8'h1) begin
         err_count++;
         $display("ERROR %0t gap %0d expected %0d", $time, gapv, exp);
      end
   endtask
   task automatic pair(input cyc_info_s a, input cyc_info_s b, input logic [7:0] e);
      m.run(a);
      m.run(b);
      cmp_gap(e);
   endtask
   // readys are sampled on the falling edge, acted on at the next rising edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      logic ta, tw, b;
      logic [1:0] r;
      n = 0;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(negedge clk);
         ta = awready & awvalid;
         tw = wready & wvalid;
         b = bvalid;
         r = bresp;
         @(posedge clk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
      end while (b !== 1'b1 && ++n < 100);
      bready <= 1'b0;
      cmp(32'(r), 32'(er));
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      int n;
      logic t, g;
      logic [31:0] d;
      logic [1:0] r;
      n = 0;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(negedge clk);
         t = arready & arvalid;
         g = rvalid;
         d = rdata;
         r = rresp;
         @(posedge clk);
         if (t) arvalid <= 1'b0;
      end while (g !== 1'b1 && ++n < 100);
      rready <= 1'b0;
      cmp(d, ed);
      cmp(32'(r), 32'(er));
   endtask
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // main sequence
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      rd(ADDR_RECOV, 32'h56, RESP_OKAY);
      rd(ADDR_DIV, 32'h3, RESP_OKAY);
      rd(8'h58, 32'h0, RESP_SLVERR);
      wr(8'h58, 32'h0, RESP_SLVERR);
      pair(IO8, IO8, 8'h7);
      pair(IO16, IO16, 8'h7);
      for (int t = 0; t < 8; t++) begin
         wr(ADDR_RECOV, {25'h0, 1'h1, 3'(t), 3'h0}, RESP_OKAY);
         pair(IO8, IO8, 8'(t == 0 ? 13 : 5 + t));
      end
      for (int t = 0; t < 4; t++) begin
         wr(ADDR_RECOV, {29'h0, 1'h1, 2'(t)}, RESP_OKAY);
         pair(IO16, IO16, 8'(t == 0 ? 9 : 5 + t));
      end
      wr(ADDR_RECOV, 32'h3B, RESP_OKAY);
      pair(IO8, IO8, 8'h5);
      pair(IO16, IO16, 8'h5);
      pair(SUB, IO8, 8'h0);
      pair(MEM, IO16, 8'h0);
      // a write with lane 0 disabled is answered but leaves the register alone
      wstrb <= 4'h0;
      wr(ADDR_RECOV, 32'h00, RESP_OKAY);
      wstrb <= 4'hF;
      rd(ADDR_RECOV, 32'h3B, RESP_OKAY);
      wr(ADDR_RECOV, 32'hFF, RESP_OKAY);
      rd(ADDR_RECOV, 32'h7F, RESP_OKAY);
      tally_and_finish();
   end
   // a hang is cut short well past the expected run length
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      $display("ERROR %0t watchdog expired", $time);
      tally_and_finish();
   end
endmodule
